// >>> hw/sfr_pkg.sv
// constants shared by the flash read and reset host controller
`default_nettype none
package sfr_pkg;
  // register offsets (byte addresses)
  localparam logic [11:0] SFR_CTRL_OFS = 12'h000;
  localparam logic [11:0] SFR_ADDR_OFS = 12'h004;
  localparam logic [11:0] SFR_LEN_OFS = 12'h008;
  localparam logic [11:0] SFR_STAT_OFS = 12'h00C;
  localparam logic [11:0] SFR_DATA_OFS = 12'h010;
  // control fields
  localparam int SFR_CTRL_START_BIT = 0;
  localparam int SFR_CTRL_CMD_LSB = 8;
  localparam int SFR_CTRL_MODE_LSB = 16;
  localparam int SFR_CTRL_CONT_BIT = 24;
  // status fields
  localparam int SFR_STAT_BUSY_BIT = 0;
  localparam int SFR_STAT_VALID_BIT = 1;
  localparam int SFR_STAT_CONT_BIT = 2;
  // opcodes
  localparam logic [7:0] SFR_OP_RST_EN = 8'h66;
  localparam logic [7:0] SFR_OP_RST = 8'h99;
  localparam logic [7:0] SFR_OP_READ = 8'h03;
  localparam logic [7:0] SFR_OP_FAST = 8'h0B;
  localparam logic [7:0] SFR_OP_DOUT = 8'h3B;
  localparam logic [7:0] SFR_OP_QOUT = 8'h6B;
  localparam logic [7:0] SFR_OP_DIO = 8'hBB;
  localparam logic [7:0] SFR_OP_QIO = 8'hEB;
  localparam logic [7:0] SFR_OP_WQIO = 8'hE7;
  localparam logic [7:0] SFR_OP_WRAP = 8'h77;
  // continuous read: opcode_skip_select = 2'b10
  localparam logic [1:0] SFR_SKIP_SEL = 2'b10;
  localparam logic [7:0] SFR_MODE_SKIP = 8'h20;
  // timing
  localparam int SFR_CLK_MHZ = 50;
  localparam int SFR_RST_US = 300;
  localparam int SFR_RST_CYC = SFR_RST_US * SFR_CLK_MHZ;
  localparam int SFR_SCK_DIV = 4;
endpackage : sfr_pkg
`default_nettype wire

// >>> hw/sfr_apb_regs.sv
// apb slave register file for the flash host controller
`default_nettype none
module sfr_apb_regs
  import sfr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic start_out,
  output logic [7:0] cmd_out,
  output logic [7:0] mode_out,
  output logic cont_out,
  output logic [23:0] addr_out,
  output logic [15:0] len_out,
  input wire logic busy_in,
  input wire logic cont_state_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_pop_out
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic start;
    logic [7:0] cmd;
    logic [7:0] mode;
    logic cont;
    logic [23:0] addr;
    logic [15:0] len;
    logic pop;
  } sfr_regs_t;
  sfr_regs_t s_q, s_d;
  logic acc;
  assign acc = psel_in && penable_in && !s_q.ready;
  always_comb begin
    s_d = s_q;
    s_d.ready = acc;
    s_d.err = 1'b0;
    s_d.start = 1'b0;
    s_d.pop = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (acc) begin
      case (paddr_in)
        SFR_CTRL_OFS: s_d.rdata = {7'h00, s_q.cont, s_q.mode, s_q.cmd, 8'h00};
        SFR_ADDR_OFS: s_d.rdata = {8'h00, s_q.addr};
        SFR_LEN_OFS: s_d.rdata = {16'h0000, s_q.len};
        SFR_STAT_OFS: begin
          s_d.rdata = {29'h0, cont_state_in, rx_valid_in, busy_in};
        end
        SFR_DATA_OFS: begin
          // reading pops the received byte
          s_d.rdata = {23'h0, rx_valid_in, rx_data_in};
          s_d.pop = !pwrite_in && rx_valid_in;
        end
        default: s_d.err = 1'b1;
      endcase
    end
    // writes land only at the edge where the master sees pready
    if (psel_in && penable_in && pwrite_in && s_q.ready) begin
      case (paddr_in)
        SFR_CTRL_OFS: begin
          s_d.start = pwdata_in[SFR_CTRL_START_BIT] && !busy_in;
          s_d.cmd = pwdata_in[SFR_CTRL_CMD_LSB +: 8];
          s_d.mode = pwdata_in[SFR_CTRL_MODE_LSB +: 8];
          s_d.cont = pwdata_in[SFR_CTRL_CONT_BIT];
        end
        SFR_ADDR_OFS: s_d.addr = pwdata_in[23:0];
        SFR_LEN_OFS: s_d.len = pwdata_in[15:0];
        default: s_d.addr = s_q.addr;
      endcase
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) s_q <= '0;
    else s_q <= s_d;
  end
  assign prdata_out = s_q.rdata;
  assign pready_out = s_q.ready;
  assign pslverr_out = s_q.err;
  assign start_out = s_q.start;
  assign cmd_out = s_q.cmd;
  assign mode_out = s_q.mode;
  assign cont_out = s_q.cont;
  assign addr_out = s_q.addr;
  assign len_out = s_q.len;
  assign rx_pop_out = s_q.pop;
endmodule : sfr_apb_regs
`default_nettype wire

// >>> hw/sfr_host.sv
// spi flash host: reset pair, read family and wrap setting frames
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`default_nettype none
module sfr_host
  import sfr_pkg::*;
#(
  parameter int RST_WAIT = SFR_RST_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic cs_n_out,
  output logic sck_out,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHIFT = 3'b001,
    ST_READ = 3'b010,
    ST_GAP = 3'b011,
    ST_WAIT = 3'b100
  } sfr_state_t;

  typedef struct packed {
    sfr_state_t st;
    logic [1:0] div;
    logic sck;
    logic cs_n;
    logic [3:0] io;
    logic [3:0] oe;
    logic [47:0] sh;
    logic [6:0] bits;
    logic [2:0] width;
    logic [3:0] dummy;
    logic [2:0] rwidth;
    logic [15:0] left;
    logic [7:0] rx;
    logic [3:0] rxbits;
    logic [7:0] rbyte;
    logic rvalid;
    logic cont;
    logic rst_armed;
    logic [31:0] wait_cnt;
  } sfr_host_t;

  sfr_host_t s_q, s_d;
  logic [3:0] io_m_q, io_s_q;
  logic start;
  logic [7:0] cmd, mode;
  logic cont_req, pop;
  logic [23:0] addr;
  logic [15:0] len;

  sfr_apb_regs u_regs (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .start_out(start),
    .cmd_out(cmd),
    .mode_out(mode),
    .cont_out(cont_req),
    .addr_out(addr),
    .len_out(len),
    .busy_in(s_q.st != ST_IDLE),
    .cont_state_in(s_q.cont),
    .rx_valid_in(s_q.rvalid),
    .rx_data_in(s_q.rbyte),
    .rx_pop_out(pop)
  );

  // data lines come from the flash, synchronise before use
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      io_m_q <= 4'h0;
      io_s_q <= 4'h0;
    end else begin
      io_m_q <= io_in;
      io_s_q <= io_m_q;
    end
  end

  // bits per clock of the address phase for a given opcode
  function automatic logic [2:0] addr_width(input logic [7:0] op);
    case (op)
      SFR_OP_DIO: addr_width = 3'd2;
      SFR_OP_QIO, SFR_OP_WQIO: addr_width = 3'd4;
      default: addr_width = 3'd1;
    endcase
  endfunction : addr_width

  function automatic logic [2:0] data_width(input logic [7:0] op);
    case (op)
      SFR_OP_DOUT, SFR_OP_DIO: data_width = 3'd2;
      SFR_OP_QOUT, SFR_OP_QIO, SFR_OP_WQIO: data_width = 3'd4;
      default: data_width = 3'd1;
    endcase
  endfunction : data_width

  // line enables for one chunk of the shift register
  function automatic logic [3:0] lane_oe(input logic [2:0] w);
    case (w)
      3'd4: lane_oe = 4'hF;
      3'd2: lane_oe = 4'h3;
      default: lane_oe = 4'h1;
    endcase
  endfunction : lane_oe

  // msb-first chunk of the shift register placed on the lines
  function automatic logic [3:0] lane_io(input logic [47:0] sh, input logic [2:0] w);
    case (w)
      3'd4: lane_io = sh[47:44];
      3'd2: lane_io = {2'b00, sh[47:46]};
      default: lane_io = {3'b000, sh[47]};
    endcase
  endfunction : lane_io

  logic tick, rise_tick, fall_tick;
  assign tick = (s_q.div == 2'(SFR_SCK_DIV / 2 - 1));
  assign rise_tick = tick && !s_q.sck;
  assign fall_tick = tick && s_q.sck;

  always_comb begin
    logic [2:0] aw;
    logic is_mode_op, skip;
    aw = addr_width(cmd);
    is_mode_op = (cmd == SFR_OP_DIO) || (cmd == SFR_OP_QIO) || (cmd == SFR_OP_WQIO);
    skip = s_q.cont && is_mode_op;
    s_d = s_q;
    if (pop) s_d.rvalid = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        s_d.cs_n = 1'b1;
        s_d.sck = 1'b0;
        s_d.oe = 4'h0;
        s_d.div = 2'd0;
        if (start) begin
          s_d.cs_n = 1'b0;
          s_d.st = ST_SHIFT;
          s_d.rwidth = data_width(cmd);
          s_d.left = len;
          s_d.dummy = 4'd0;
          if (cmd == SFR_OP_RST_EN || cmd == SFR_OP_RST) begin
            // each opcode in its own frame
            s_d.sh = {cmd, 40'h0};
            s_d.bits = 7'd8;
            s_d.width = 3'd1;
            s_d.left = 16'd0;
          end else if (cmd == SFR_OP_WRAP) begin
            // opcode, 24 dummy bits, wrap byte
            s_d.sh = {cmd, 24'h000000, mode, 8'h00};
            s_d.bits = 7'd40;
            s_d.width = 3'd1;
            s_d.left = 16'd0;
          end else if (is_mode_op) begin
            s_d.width = aw;
            s_d.sh = skip ? {addr, cont_req ? SFR_MODE_SKIP : mode, 16'h0}
                          : {cmd, addr, cont_req ? SFR_MODE_SKIP : mode, 8'h0};
            s_d.bits = skip ? 7'd32 : 7'd40;
            s_d.dummy = (cmd == SFR_OP_QIO) ? 4'd4 : (cmd == SFR_OP_WQIO) ? 4'd2 : 4'd0;
            if (cmd == SFR_OP_WQIO) s_d.sh[skip ? 24 : 16] = 1'b0;
          end else begin
            // single line header, dummy byte for fast ones
            s_d.width = 3'd1;
            s_d.sh = {cmd, addr, 16'h0};
            s_d.bits = (cmd == SFR_OP_READ) ? 7'd32 : 7'd40;
          end
          if (s_d.width == 3'd1 || !skip) s_d.width = 3'd1;
          // first chunk stands before the first rising clock edge
          s_d.io = lane_io(s_d.sh, s_d.width);
          s_d.oe = lane_oe(s_d.width);
        end
      end
      ST_SHIFT: begin
        s_d.div = tick ? 2'd0 : s_q.div + 2'd1;
        if (tick) s_d.sck = !s_q.sck;
        if (fall_tick && s_q.bits != 7'd0) begin
          s_d.sh = s_q.sh << s_q.width;
          s_d.bits = s_q.bits - 7'(s_q.width);
          // opcode sent serially, then multi-line phase
          if (s_q.bits == 7'd33 && addr_width(cmd) != 3'd1) begin
            s_d.width = addr_width(cmd);
          end
          // next chunk changes while the clock is low
          s_d.io = lane_io(s_d.sh, s_d.width);
          s_d.oe = lane_oe(s_d.width);
        end
        if (fall_tick && s_q.bits == 7'(s_q.width)) begin
          // release lines for dummies and data
          s_d.oe = 4'h0;
          s_d.bits = 7'd0;
          if (s_q.left == 16'd0) s_d.st = ST_GAP;
          else if (s_q.dummy != 4'd0) s_d.st = ST_SHIFT;
          else s_d.st = ST_READ;
        end
        if (fall_tick && s_q.bits == 7'd0) begin
          if (s_q.dummy > 4'd1) s_d.dummy = s_q.dummy - 4'd1;
          else begin
            s_d.dummy = 4'd0;
            s_d.st = ST_READ;
          end
        end
      end
      ST_READ: begin
        // device streams; host stops after len bytes
        s_d.div = tick ? 2'd0 : s_q.div + 2'd1;
        if (tick && !(s_q.rvalid && !pop && rise_tick)) s_d.sck = !s_q.sck;
        if (tick && s_q.rvalid && !pop && rise_tick) s_d.div = s_q.div;
        // sample mid high phase: data needs the two sync flops
        if (s_q.sck && s_q.div == 2'd0) begin
          s_d.rx = (s_q.rwidth == 3'd4) ? {s_q.rx[3:0], io_s_q} :
                   (s_q.rwidth == 3'd2) ? {s_q.rx[5:0], io_s_q[1:0]} :
                   {s_q.rx[6:0], io_s_q[1]};
          s_d.rxbits = s_q.rxbits + 4'(s_q.rwidth);
          if (s_d.rxbits == 4'd8) begin
            s_d.rbyte = s_d.rx;
            s_d.rvalid = 1'b1;
            s_d.rxbits = 4'd0;
            s_d.left = s_q.left - 16'd1;
            if (s_q.left == 16'd1) s_d.st = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        s_d.sck = 1'b0;
        s_d.cs_n = 1'b1;
        s_d.oe = 4'h0;
        s_d.rxbits = 4'd0;
        if (cmd == SFR_OP_DIO || cmd == SFR_OP_QIO || cmd == SFR_OP_WQIO) begin
          s_d.cont = cont_req || (mode[5:4] == SFR_SKIP_SEL);
        end
        s_d.rst_armed = (cmd == SFR_OP_RST_EN);
        if (cmd == SFR_OP_RST && s_q.rst_armed) begin
          s_d.cont = 1'b0;
          s_d.wait_cnt = 32'(RST_WAIT);
          s_d.st = ST_WAIT;
        end else begin
          s_d.st = ST_IDLE;
        end
      end
      ST_WAIT: begin
        s_d.wait_cnt = s_q.wait_cnt - 32'd1;
        if (s_q.wait_cnt <= 32'd1) s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.cs_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cs_n_out = s_q.cs_n;
  assign sck_out = s_q.sck;
  assign io_out = s_q.io;
  assign io_oe_out = s_q.oe;
endmodule : sfr_host
`default_nettype wire

// >>> dv/sfr_host_chk.sv
// port checker for the flash host controller
`default_nettype none
module sfr_host_chk
  import sfr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cs_n_out,
  input wire logic sck_out,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence apb_wait_s;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence sck_high_s;
    sck_out ##1 !sck_out;
  endsequence
  idle_sck_low_a: assert property (cs_n_out |-> !sck_out)
    else $error("serial clock high while deselected");
  idle_release_a: assert property (cs_n_out |-> io_oe_out == 4'h0)
    else $error("data lines driven while deselected");
  frame_gap_a: assert property ($rose(cs_n_out) |=> cs_n_out)
    else $error("frames not separated by an idle cycle");
  opcode_drive_a: assert property ($fell(cs_n_out) |-> ##[0:2] io_oe_out[0])
    else $error("host not driving line 0 at frame start");
  sck_shape_a: assert property ($rose(sck_out) |=> sck_high_s)
    else $error("serial clock high phase not two cycles");
  bit_steady_a: assert property ($rose(sck_out) |=> $stable(io_out))
    else $error("data changed while serial clock high");
  apb_answer_a: assert property (apb_wait_s |-> ##[1:2] pready_out)
    else $error("apb answer late");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
endmodule : sfr_host_chk
bind sfr_host sfr_host_chk u_chk (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .cs_n_out(cs_n_out), .sck_out(sck_out), .io_in(io_in), .io_out(io_out),
  .io_oe_out(io_oe_out));
`default_nettype wire

// >>> dv/sfr_flash_model.sv
// behavioural serial flash answering read, wrap and reset frames
`default_nettype none
module sfr_flash_model
  import sfr_pkg::*;
#(
  parameter bit QUAD_IO_ENABLE_BIT = 1'b1,
  parameter int BUSY_NS = 300
) (
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] op_q, cop_q, mode_q, b;
  logic [23:0] addr_q, a, wl;
  logic [63:0] sh_q;
  logic [2:0] wrap_q = 3'b111;
  logic cont_q = 1'b0;
  logic ren_q = 1'b0;
  int c, w, lw, ow, oc, ac, mc, dc, bi;
  int err_cnt = 0;
  int rst_cnt = 0;
  realtime bsy_until = 0;
  function automatic logic [7:0] mem_byte(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'hA5;
  endfunction : mem_byte
  task automatic decode;
    lw = (op_q == SFR_OP_DIO) ? 2 : (op_q inside {SFR_OP_QIO, SFR_OP_WQIO}) ? 4 : 1;
    ow = (op_q inside {SFR_OP_DOUT, SFR_OP_DIO}) ? 2 : 0;
    if (op_q inside {SFR_OP_READ, SFR_OP_FAST}) ow = 1;
    if (op_q inside {SFR_OP_QOUT, SFR_OP_QIO, SFR_OP_WQIO}) begin
      ow = QUAD_IO_ENABLE_BIT ? 4 : 0;
    end
    ac = oc + 24 / lw;
    mc = (lw > 1) ? 8 / lw : (op_q == SFR_OP_WRAP) ? 8 : 0;
    dc = (op_q == SFR_OP_QIO) ? 4 : (op_q == SFR_OP_WQIO) ? 2 : 0;
    if (op_q inside {SFR_OP_FAST, SFR_OP_DOUT, SFR_OP_QOUT}) dc = 8;
  endtask : decode
  initial begin
    io_out = 4'h0;
    io_oe_out = 4'h0;
  end
  always @(negedge cs_n_in) begin
    c = 0;
    if ($realtime < bsy_until) err_cnt++;
    oc = cont_q ? 0 : 8;
    op_q = cop_q;
    if (cont_q) decode();
  end
  always @(posedge sck_in) begin
    if (!cs_n_in) begin
      w = (c < oc) ? 1 : lw;
      sh_q = (sh_q << w) | 64'(io_in & 4'((1 << w) - 1));
      c++;
      if (c == 8 && oc == 8) begin
        op_q = sh_q[7:0];
        decode();
      end
      if (c == ac) addr_q = sh_q[23:0];
      if (mc > 0 && c == ac + mc) mode_q = sh_q[7:0];
    end
  end
  always @(negedge sck_in) begin
    if (!cs_n_in && ow > 0 && c >= ac + mc + dc) begin
      bi = (c - ac - mc - dc) * ow;
      a = addr_q + 24'(bi / 8);
      if (lw == 4 && !wrap_q[0]) begin
        wl = 24'(8 << wrap_q[2:1]);
        a = (addr_q & ~(wl - 24'h1)) | (a & (wl - 24'h1));
      end
      b = mem_byte(a) << (bi % 8);
      io_oe_out = (ow == 1) ? 4'h2 : (ow == 2) ? 4'h3 : 4'hF;
      io_out = (ow == 1) ? {2'b00, b[7], 1'b0} : (ow == 2) ? {2'b00, b[7:6]} : b[7:4];
    end
  end
  always @(posedge cs_n_in) begin
    io_oe_out = 4'h0;
    if (op_q == SFR_OP_WRAP && c >= 40) wrap_q = mode_q[6:4];
    if (lw > 1 && ow > 0 && c >= ac + mc) begin
      cont_q = (mode_q[5:4] == SFR_SKIP_SEL);
      cop_q = op_q;
    end
    if (ren_q && oc == 8 && c == 8 && op_q == SFR_OP_RST) begin
      cont_q = 1'b0;
      wrap_q = 3'b111;
      rst_cnt++;
      bsy_until = $realtime + BUSY_NS;
    end
    ren_q = (oc == 8 && c == 8 && op_q == SFR_OP_RST_EN);
  end
endmodule : sfr_flash_model
`default_nettype wire

// >>> dv/tb_spi_flash_read_and_reset.sv
// testbench for the flash host controller against the flash model
`default_nettype none
module tb_spi_flash_read_and_reset
  import sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, perr_w, cs_n, sck, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] io_o, io_oe, m_d, m_oe, io_w;
  logic [3:0] flt = 4'h5;
  logic [23:0] wl;
  logic [7:0] ops [6] = '{SFR_OP_FAST, SFR_OP_DOUT, SFR_OP_QOUT, SFR_OP_DIO, SFR_OP_QIO,
    SFR_OP_WQIO};
  logic [7:0] cops [7] = '{SFR_OP_DIO, SFR_OP_DIO, SFR_OP_DIO, SFR_OP_QIO, SFR_OP_QIO,
    SFR_OP_WQIO, SFR_OP_WQIO};
  int n_mismatch = 0;
  int n_tests = 0;
  // undriven lines toggle so a stale level never passes as data
  assign io_w = (io_oe & io_o) | (~io_oe & m_oe & m_d) | (~io_oe & ~m_oe & flt);
  always @(posedge clk) flt <= ~flt;
  sfr_host #(.RST_WAIT(20)) uut (.clock_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr_w), .cs_n_out(cs_n),
    .sck_out(sck), .io_in(io_w), .io_out(io_o), .io_oe_out(io_oe));
  sfr_flash_model u_flash (.cs_n_in(cs_n), .sck_in(sck), .io_in(io_w), .io_out(m_d),
    .io_oe_out(m_oe));
  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait-state count assumed: only the watchdog ends this
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    perr = perr_w;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic frame(input logic [7:0] op, input logic [7:0] md, input logic [23:0] a,
    input int len);
    int i, n;
    logic [23:0] x;
    apb(1'b1, SFR_ADDR_OFS, {8'h00, a});
    apb(1'b1, SFR_LEN_OFS, 32'(len));
    apb(1'b1, SFR_CTRL_OFS, {8'h00, md, op, 8'h01});
    for (i = 0; i < len; i++) begin
      n = 0;
      do begin
        apb(1'b0, SFR_DATA_OFS, 32'h0);
        n++;
      end while (rdat[8] !== 1'b1 && n < 200);
      x = a + 24'(i);
      if (wl != 0) x = (a & ~(wl - 24'h1)) | (x & (wl - 24'h1));
      chk(32'(rdat[8:0]), {23'h0, 1'b1, u_flash.mem_byte(x)});
    end
    n = 0;
    do begin
      apb(1'b0, SFR_STAT_OFS, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 200);
  endtask : frame
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1ms;
    n_mismatch++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, wl} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, SFR_STAT_OFS, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(32'(perr), 32'h1);
    frame(SFR_OP_READ, 8'h00, 24'h0000FE, 4);
    for (int i = 0; i < 6; i++) begin
      frame(ops[i], 8'h00, 24'h012340 + 24'(2 * i), 3);
    end
    for (int i = 0; i < 7; i++) begin
      frame(cops[i], (i inside {0, 1, 3, 5}) ? SFR_MODE_SKIP : 8'h00,
        24'h020000 + 24'(16 * i), 2);
      chk(32'(rdat[2]), (i inside {0, 1, 3, 5}) ? 32'h1 : 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      frame(SFR_OP_WRAP, {1'b0, 2'(i), 5'h00}, 24'h0, 0);
      wl = 24'(8 << i);
      frame(SFR_OP_QIO, 8'h00, 24'h00013E, 6);
      wl = 24'h0;
    end
    frame(SFR_OP_RST_EN, 8'h00, 24'h0, 0);
    frame(SFR_OP_READ, 8'h00, 24'h000010, 1);
    frame(SFR_OP_RST, 8'h00, 24'h0, 0);
    chk(32'(u_flash.wrap_q), 32'h6);
    frame(SFR_OP_RST_EN, 8'h00, 24'h0, 0);
    frame(SFR_OP_RST, 8'h00, 24'h0, 0);
    chk(32'(u_flash.rst_cnt), 32'h1);
    frame(SFR_OP_QIO, 8'h00, 24'h00013E, 4);
    chk(32'(u_flash.err_cnt), 32'h0);
    conclude();
  end
endmodule : tb_spi_flash_read_and_reset
`default_nettype wire
